// file: hdl/task_io_pkg.sv
// Package for the parallel motion-task I/O interface: register map,
// field positions, reset values, timing counts and carrier structs.
// Assumes a 250 MHz core clock and a 32-bit APB register bus.
`default_nettype none

package task_io_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_MHZ = 250;
   localparam int unsigned ADDR_SETTLE_MS = 4;
   localparam int unsigned START_DELAY_MAX_MS = 2;
   localparam int unsigned ADDR_SETTLE_CYC = ADDR_SETTLE_MS * 1000 * CLK_MHZ;
   localparam int unsigned START_DELAY_CYC = START_DELAY_MAX_MS * 1000 * CLK_MHZ;

   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STATUS_OFS = 8'h04;
   localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
   localparam logic [7:0] IRQ_MASK_OFS = 8'h0c;
   localparam logic [7:0] REQ_OFS = 8'h10;
   localparam logic [7:0] MOTION_OFS = 8'h14;
   localparam logic [7:0] PREG_OFS = 8'h18;

   // CTRL fields
   localparam int CTRL_BASE_REF_BIT = 0;
   localparam int CTRL_BASE_NEXT_BIT = 1;
   localparam int CTRL_BASE_RESUME_BIT = 2;
   localparam int CTRL_PROG_MODE_LSB = 4;
   localparam int CTRL_FLAG0_CE_BIT = 6;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

   // Motion status fields (written by the position controller side)
   localparam int MOT_IN_POS_BIT = 0;
   localparam int MOT_SEQ_START_BIT = 1;
   localparam int MOT_SEQ_FIRST_BIT = 2;
   localparam int MOT_CONTOUR_BIT = 3;
   localparam int MOT_WARN_BIT = 4;

   // Event / interrupt bit positions
   localparam int EV_START = 0;
   localparam int EV_NEXT = 1;
   localparam int EV_RESUME = 2;
   localparam int EV_JOG_ON = 3;
   localparam int EV_JOG_OFF = 4;
   localparam int EV_CLEAR = 5;
   localparam int EV_REF = 6;
   localparam int EV_LATE = 7;
   localparam int EV_W = 8;

   // Sequence-progress signalling forms
   typedef enum logic [1:0] {
      PROG_TOGGLE = 2'h0,
      PROG_PULSE = 2'h1,
      PROG_LEVEL = 2'h2,
      PROG_OFF = 2'h3
   } prog_mode_t;

   typedef enum logic [2:0] {
      REQ_NONE = 3'h0,
      REQ_START = 3'h1,
      REQ_NEXT = 3'h2,
      REQ_RESUME = 3'h3,
      REQ_JOG_ON = 3'h4,
      REQ_JOG_OFF = 3'h5
   } req_kind_t;

   // Card input bundle
   typedef struct packed {
      logic [7:0] task_sel;
      logic ref_sw;
      logic follow_err_clear;
      logic next_task_start;
      logic jog;
      logic task_resume;
      logic task_start_sel;
   } card_in_t;

   // Base-unit digital inputs that share functions with the card
   typedef struct packed {
      logic [7:0] task_sel;
      logic task_start;
      logic next_task_start;
      logic task_resume;
      logic ref_sw;
   } base_in_t;

   // Request to the position controller
   typedef struct packed {
      logic valid;
      req_kind_t kind;
      logic [7:0] task_num;
      logic from_base;
   } motion_req_t;

endpackage

`default_nettype wire

// file: hdl/motion_task_io_interface.sv
// Parallel motion-task I/O interface: strobe decoding, request issue to
// the position controller, output signalling and an APB register file.
// Assumes all card and base inputs arrive asynchronously to clock and
// that the position controller acknowledges requests with req_ack.
//
// Summary of operation
// (RL1) Task number: eight select bits, bit0 LSB.
// (RL2) Start strobe begins task from select inputs.
// (RL3) Base start uses base unit select inputs.
// (RL4) Ignore card reference when base reference configured.
// (RL5) Error clear drops following/monitoring warnings.
// (RL6) Next task waits for target position.
// (RL7) Base input may also start next task.
// (RL8) Jog rising starts, falling cancels.
// (RL9) Restart resumes interrupted task; base too.
// (RL10) In-position high when target within window.
// (RL11) Progress output inverts at each sequence task.
// (RL12) Progress output low at sequence's first task.
// (RL13) Progress signalling form is configurable.
// (RL14) Flag0 may show low-active contouring error.
// (RL15) Position flag high while preset active.
// (RL16) Controller holds task number 4 ms before strobe.
// (RL17) Motion begins within 2 ms of strobe.
// (RL18) Inputs synchronised, one request per edge.
//
// The APB slave port and the register addresses were left to the implementer.
`default_nettype none

module motion_task_io_interface #(
   parameter int unsigned START_DELAY_CYC = task_io_pkg::START_DELAY_CYC
) (
   input wire logic clock, // Core clock
   input wire logic rst_n, // Synchronous reset
   input wire task_io_pkg::card_in_t card_in, // Card inputs, async
   input wire task_io_pkg::base_in_t base_in, // Base-unit inputs, async
   input wire logic [5:0] preset_active, // Position register presets
   input wire logic req_ack, // Controller took the request
   input wire logic [31:0] motion_stat, // Controller status word
   output task_io_pkg::motion_req_t motion_req, // Request to controller
   output logic warn_clear, // One-cycle warning clear
   output logic ref_switch, // Selected reference switch
   output logic in_position_out, // Target reached
   output logic sequence_progress_out, // Sequence progress
   output logic [5:0] pos_flag_out, // Position flags, 0 may be error
   output logic irq, // Level interrupt
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction
   input wire logic [7:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr // APB error
);

   // ----------------------------------------------------------------
   // Input synchronisers and edge detection
   // ----------------------------------------------------------------
   localparam int NIN = $bits(task_io_pkg::card_in_t) + $bits(task_io_pkg::base_in_t);

   logic [NIN-1:0] meta_q, sync_q, prev_q;
   task_io_pkg::card_in_t card_s, card_p;
   task_io_pkg::base_in_t base_s, base_p;

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         meta_q <= '0;
         sync_q <= '0;
         prev_q <= '0;
      end else begin
         meta_q <= {card_in, base_in};
         sync_q <= meta_q; // RL18
         prev_q <= sync_q;
      end
   end

   assign {card_s, base_s} = sync_q;
   assign {card_p, base_p} = prev_q;

   function automatic logic rise(input logic now, input logic was);
      rise = now & ~was;
   endfunction

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [31:0] ctrl_q;
   logic [task_io_pkg::EV_W-1:0] ev_stat_q, ev_mask_q, ev_set;
   logic base_ref_cfg, base_next_cfg, base_resume_cfg, flag0_ce;
   task_io_pkg::prog_mode_t prog_mode;

   assign base_ref_cfg = ctrl_q[task_io_pkg::CTRL_BASE_REF_BIT];
   assign base_next_cfg = ctrl_q[task_io_pkg::CTRL_BASE_NEXT_BIT];
   assign base_resume_cfg = ctrl_q[task_io_pkg::CTRL_BASE_RESUME_BIT];
   assign prog_mode = task_io_pkg::prog_mode_t'(ctrl_q[task_io_pkg::CTRL_PROG_MODE_LSB +: 2]);
   assign flag0_ce = ctrl_q[task_io_pkg::CTRL_FLAG0_CE_BIT];

   // ----------------------------------------------------------------
   // Strobe decoding
   // ----------------------------------------------------------------
   logic start_card, start_base, next_ev, resume_ev, jog_on, jog_off, clr_ev;
   logic in_pos;

   assign in_pos = motion_stat[task_io_pkg::MOT_IN_POS_BIT];
   assign start_card = rise(card_s.task_start_sel, card_p.task_start_sel); // RL2
   assign start_base = rise(base_s.task_start, base_p.task_start); // RL3
   assign next_ev = rise(card_s.next_task_start, card_p.next_task_start)
      | (base_next_cfg & rise(base_s.next_task_start, base_p.next_task_start)); // RL7
   assign resume_ev = rise(card_s.task_resume, card_p.task_resume)
      | (base_resume_cfg & rise(base_s.task_resume, base_p.task_resume)); // RL9
   assign jog_on = rise(card_s.jog, card_p.jog); // RL8
   assign jog_off = rise(card_p.jog, card_s.jog); // RL8
   assign clr_ev = rise(card_s.follow_err_clear, card_p.follow_err_clear); // RL5

   // ----------------------------------------------------------------
   // Pending requests, issued one at a time
   // ----------------------------------------------------------------
   logic start_pend_q, start_src_q, next_pend_q, resume_pend_q, jogon_pend_q, jogoff_pend_q;
   logic [7:0] start_num_q;
   logic issue;
   task_io_pkg::req_kind_t pick;

   // Cancel outranks a stale jog start; next waits for in-position
   always_comb begin
      pick = task_io_pkg::REQ_NONE;
      if (jogoff_pend_q)
         pick = task_io_pkg::REQ_JOG_OFF; // RL8
      else if (start_pend_q)
         pick = task_io_pkg::REQ_START;
      else if (resume_pend_q)
         pick = task_io_pkg::REQ_RESUME;
      else if (jogon_pend_q)
         pick = task_io_pkg::REQ_JOG_ON;
      else if (next_pend_q && in_pos)
         pick = task_io_pkg::REQ_NEXT; // RL6
   end

   assign issue = !motion_req.valid && (pick != task_io_pkg::REQ_NONE);

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         start_pend_q <= 1'b0;
         start_src_q <= 1'b0;
         start_num_q <= 8'h00;
         next_pend_q <= 1'b0;
         resume_pend_q <= 1'b0;
         jogon_pend_q <= 1'b0;
         jogoff_pend_q <= 1'b0;
      end else begin
         // Task number latched at the strobe; host held it steady beforehand
         if (start_card || start_base) begin
            start_pend_q <= 1'b1;
            start_src_q <= start_base && !start_card;
            start_num_q <= start_card ? card_s.task_sel : base_s.task_sel; // RL1 RL16
         end else if (issue && pick == task_io_pkg::REQ_START)
            start_pend_q <= 1'b0;
         if (next_ev)
            next_pend_q <= 1'b1;
         else if (issue && pick == task_io_pkg::REQ_NEXT)
            next_pend_q <= 1'b0;
         if (resume_ev)
            resume_pend_q <= 1'b1;
         else if (issue && pick == task_io_pkg::REQ_RESUME)
            resume_pend_q <= 1'b0;
         if (jog_on)
            jogon_pend_q <= 1'b1;
         else if (jog_off || (issue && pick == task_io_pkg::REQ_JOG_ON))
            jogon_pend_q <= 1'b0;
         if (jog_off)
            jogoff_pend_q <= 1'b1;
         else if (issue && pick == task_io_pkg::REQ_JOG_OFF)
            jogoff_pend_q <= 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n)
         motion_req <= '0;
      else if (issue) begin
         motion_req.valid <= 1'b1;
         motion_req.kind <= pick;
         motion_req.task_num <= start_num_q;
         motion_req.from_base <= (pick == task_io_pkg::REQ_START) && start_src_q;
      end else if (req_ack)
         motion_req.valid <= 1'b0;
   end

   // Watchdog on the controller's acceptance
   logic [$clog2(START_DELAY_CYC+1)-1:0] wait_q;
   logic late;

   always_ff @(posedge clock) begin
      if (!rst_n || !motion_req.valid || req_ack)
         wait_q <= '0;
      else if (wait_q != START_DELAY_CYC[$bits(wait_q)-1:0])
         wait_q <= wait_q + 1'b1;
   end

   assign late = motion_req.valid && !req_ack
      && (wait_q == START_DELAY_CYC[$bits(wait_q)-1:0] - 1'b1); // RL17

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   logic seq_start, seq_first;

   assign seq_start = motion_stat[task_io_pkg::MOT_SEQ_START_BIT];
   assign seq_first = motion_stat[task_io_pkg::MOT_SEQ_FIRST_BIT];

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         warn_clear <= 1'b0;
         ref_switch <= 1'b0;
         in_position_out <= 1'b0;
         pos_flag_out <= 6'h00;
      end else begin
         warn_clear <= clr_ev; // RL5
         ref_switch <= base_ref_cfg ? base_s.ref_sw : card_s.ref_sw; // RL4
         in_position_out <= in_pos; // RL10
         pos_flag_out <= preset_active; // RL15
         if (flag0_ce)
            pos_flag_out[0] <= ~motion_stat[task_io_pkg::MOT_CONTOUR_BIT]; // RL14
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n)
         sequence_progress_out <= 1'b0;
      else begin
         case (prog_mode) // RL13
            task_io_pkg::PROG_TOGGLE: begin
               if (seq_start && seq_first)
                  sequence_progress_out <= 1'b0; // RL12
               else if (seq_start)
                  sequence_progress_out <= ~sequence_progress_out; // RL11
            end
            task_io_pkg::PROG_PULSE:
               sequence_progress_out <= seq_start && !seq_first;
            task_io_pkg::PROG_LEVEL:
               sequence_progress_out <= in_pos && !seq_start;
            default:
               sequence_progress_out <= 1'b0;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Events and interrupt
   // ----------------------------------------------------------------
   always_comb begin
      ev_set = '0;
      ev_set[task_io_pkg::EV_START] = start_card | start_base;
      ev_set[task_io_pkg::EV_NEXT] = next_ev;
      ev_set[task_io_pkg::EV_RESUME] = resume_ev;
      ev_set[task_io_pkg::EV_JOG_ON] = jog_on;
      ev_set[task_io_pkg::EV_JOG_OFF] = jog_off;
      ev_set[task_io_pkg::EV_CLEAR] = clr_ev;
      ev_set[task_io_pkg::EV_REF] = ref_switch ^ (base_ref_cfg ? base_s.ref_sw : card_s.ref_sw);
      ev_set[task_io_pkg::EV_LATE] = late;
   end

   // ----------------------------------------------------------------
   // APB slave, zero wait states
   // ----------------------------------------------------------------
   logic wr_acc, rd_setup, hit;

   assign wr_acc = psel && penable && pwrite;
   assign rd_setup = psel && !penable;

   function automatic logic mapped(input logic [7:0] a);
      mapped = a == task_io_pkg::CTRL_OFS || a == task_io_pkg::STATUS_OFS
         || a == task_io_pkg::IRQ_STAT_OFS || a == task_io_pkg::IRQ_MASK_OFS
         || a == task_io_pkg::REQ_OFS || a == task_io_pkg::MOTION_OFS
         || a == task_io_pkg::PREG_OFS;
   endfunction

   assign hit = mapped(paddr);

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         ctrl_q <= task_io_pkg::CTRL_RESET;
         ev_mask_q <= '0;
      end else if (wr_acc) begin
         if (paddr == task_io_pkg::CTRL_OFS)
            ctrl_q <= pwdata;
         if (paddr == task_io_pkg::IRQ_MASK_OFS)
            ev_mask_q <= pwdata[task_io_pkg::EV_W-1:0];
      end
   end

   // Set beats write-one-to-clear in the same cycle
   always_ff @(posedge clock) begin
      if (!rst_n)
         ev_stat_q <= '0;
      else if (wr_acc && paddr == task_io_pkg::IRQ_STAT_OFS)
         ev_stat_q <= (ev_stat_q & ~pwdata[task_io_pkg::EV_W-1:0]) | ev_set;
      else
         ev_stat_q <= ev_stat_q | ev_set;
   end

   always_ff @(posedge clock) begin
      if (!rst_n)
         irq <= 1'b0;
      else
         irq <= |(ev_stat_q & ev_mask_q);
   end

   // Read data is captured in setup so the access phase completes at once
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= rd_setup;
         pslverr <= rd_setup && !hit;
         if (rd_setup && !pwrite) begin
            case (paddr)
               task_io_pkg::CTRL_OFS: prdata <= ctrl_q;
               task_io_pkg::STATUS_OFS: prdata <= {16'h0000, card_s, ref_switch, base_s.ref_sw};
               task_io_pkg::IRQ_STAT_OFS: prdata <= {24'h000000, ev_stat_q};
               task_io_pkg::IRQ_MASK_OFS: prdata <= {24'h000000, ev_mask_q};
               task_io_pkg::REQ_OFS: prdata <= {16'h0000, start_num_q, next_pend_q,
                  start_pend_q, resume_pend_q, jogon_pend_q, motion_req.valid,
                  motion_req.kind};
               task_io_pkg::MOTION_OFS: prdata <= motion_stat;
               task_io_pkg::PREG_OFS: prdata <= {24'h000000, sequence_progress_out,
                  in_position_out, pos_flag_out};
               default: prdata <= 32'h0000_0000;
            endcase
         end else
            prdata <= 32'h0000_0000;
      end
   end

endmodule

`default_nettype wire

// file: verification/task_io_properties.sv
// Checker for the motion-task I/O interface, bound to its top module.
// Assumes one outstanding request at a time from the stimulus side.
`default_nettype none
module task_io_properties (
   input wire logic clock, // Core clock
   input wire logic rst_n, // Sync reset
   input wire task_io_pkg::card_in_t card_in, // Card inputs
   input wire logic [5:0] preset_active, // Presets
   input wire logic req_ack, // Request taken
   input wire logic [31:0] motion_stat, // Status word
   input wire task_io_pkg::motion_req_t motion_req, // Request out
   input wire logic warn_clear, // Clear pulse
   input wire logic in_position_out, // In position
   input wire logic [5:0] pos_flag_out, // Position flags
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pready, // APB ready
   input wire logic pslverr // APB error
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   // ----------------------------------------------------------------
   // Request handshake
   // ----------------------------------------------------------------
   sequence s_start_edge;
      $rose(card_in.task_start_sel) && !motion_req.valid;
   endsequence
   sequence s_req_up;
      ##[1:8] motion_req.valid;
   endsequence
   AST_START_BOUND: assert property (s_start_edge |-> s_req_up)
      else $error("start strobe gave no request");
   AST_REQ_HOLD: assert property (motion_req.valid && !req_ack |=>
      motion_req.valid && $stable(motion_req))
      else $error("request changed before ack");
   AST_REQ_DROP: assert property (motion_req.valid && req_ack |=> !motion_req.valid)
      else $error("request stayed after ack");
   AST_NEXT_WAIT: assert property ($rose(motion_req.valid) &&
      motion_req.kind == task_io_pkg::REQ_NEXT |-> $past(motion_stat[0]))
      else $error("next task issued before target reached");
   AST_WARN_PULSE: assert property (warn_clear |=> !warn_clear)
      else $error("warning clear longer than one cycle");
   // ----------------------------------------------------------------
   // Outputs and bus
   // ----------------------------------------------------------------
   AST_IN_POSITION_OUT: assert property ($past(rst_n) |->
      in_position_out == $past(motion_stat[0]))
      else $error("in-position output wrong");
   AST_POSFLAG: assert property ($past(rst_n) |->
      pos_flag_out[5:1] == $past(preset_active[5:1]))
      else $error("position flag wrong");
   AST_PREADY: assert property (psel && !penable |=> pready)
      else $error("bus access not answered");
   AST_SLVERR: assert property (pslverr |-> pready && psel && penable)
      else $error("bus error outside access");
endmodule

bind motion_task_io_interface task_io_properties i_props (
   .clock(clock), .rst_n(rst_n), .card_in(card_in), .preset_active(preset_active),
   .req_ack(req_ack), .motion_stat(motion_stat), .motion_req(motion_req),
   .warn_clear(warn_clear), .in_position_out(in_position_out),
   .pos_flag_out(pos_flag_out), .psel(psel), .penable(penable), .pready(pready),
   .pslverr(pslverr));
`default_nettype wire

// file: verification/plc_model.sv
// Controller-side model that drives the card's select and strobe pins.
// Assumes its tasks are called from one bench process at a time.
`default_nettype none
module plc_model #(
   parameter int SETTLE_CYC = 8
) (
   input wire logic clock, // Core clock
   output var task_io_pkg::card_in_t card_in // Card inputs
);
   timeunit 1ns;
   timeprecision 1ps;
   initial card_in = '0;
   // Bit 0 of the select field is the lowest task number bit
   task automatic select(input logic [7:0] n);
      @(posedge clock);
      card_in.task_sel <= n;
      repeat (SETTLE_CYC) @(posedge clock);
   endtask
   // Held long enough to pass the input synchroniser
   task automatic level(input int b, input logic v);
      @(posedge clock);
      card_in[b] <= v;
      repeat (8) @(posedge clock);
   endtask
   task automatic pulse(input int b);
      level(b, 1'b1);
      level(b, 1'b0);
   endtask
endmodule
`default_nettype wire

// file: verification/tb_top.sv
// Self-checking bench for the motion-task I/O interface.
// Assumes the checker is bound and the controller model drives the card.
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int B_START = 0;
   localparam int B_RES = 1;
   localparam int B_JOG = 2;
   localparam int B_NEXT = 3;
   localparam int B_CLR = 4;
   localparam int B_REF = 5;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   task_io_pkg::card_in_t card_in;
   task_io_pkg::base_in_t base_in = '0;
   logic [5:0] preset_active = '0;
   logic req_ack = 1'b0;
   logic [31:0] motion_stat = 32'h1;
   task_io_pkg::motion_req_t motion_req;
   logic warn_clear, ref_switch, in_position_out, sequence_progress_out, irq;
   logic [5:0] pos_flag_out;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = '0, last_num;
   logic [31:0] pwdata = '0, prdata, rd;
   logic pready, pslverr, err;
   int failures = 0;
   int check_count = 0;
   always #2 clock = ~clock;
   plc_model #(.SETTLE_CYC(8)) i_plc (.clock(clock), .card_in(card_in));
   motion_task_io_interface #(.START_DELAY_CYC(20)) i_dut (
      .clock(clock), .rst_n(rst_n), .card_in(card_in), .base_in(base_in),
      .preset_active(preset_active), .req_ack(req_ack), .motion_stat(motion_stat),
      .motion_req(motion_req), .warn_clear(warn_clear), .ref_switch(ref_switch),
      .in_position_out(in_position_out), .sequence_progress_out(sequence_progress_out),
      .pos_flag_out(pos_flag_out), .irq(irq), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));
   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic exp_req(input task_io_pkg::req_kind_t k, input logic b);
      int n = 0;
      logic seen = 1'b0;
      while (motion_req.valid !== 1'b1 && n < 40) begin
         @(negedge clock);
         n++;
      end
      chk({motion_req.valid, motion_req.kind, motion_req.from_base}, {1'b1, k, b});
      last_num = motion_req.task_num;
      @(posedge clock);
      req_ack <= 1'b1;
      @(posedge clock);
      req_ack <= 1'b0;
      // A held strobe must not raise a second request
      repeat (12) begin
         @(negedge clock);
         seen = seen | motion_req.valid;
      end
      chk(seen, 1'b0);
   endtask
   task automatic bpulse(input int b);
      @(posedge clock);
      base_in[b] <= 1'b1;
      repeat (8) @(posedge clock);
      base_in[b] <= 1'b0;
      repeat (8) @(posedge clock);
   endtask
   task automatic drv_stat(input logic [31:0] v);
      @(posedge clock);
      motion_stat <= v;
      repeat (4) @(negedge clock);
   endtask
   task automatic seq(input logic [31:0] v);
      @(posedge clock);
      motion_stat <= v;
      drv_stat(32'h1);
   endtask
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_regs();
      apb(1'b0, task_io_pkg::CTRL_OFS, 32'h0);
      chk(rd, task_io_pkg::CTRL_RESET);
      apb(1'b1, 8'h40, 32'hffff_ffff);
      chk({err, rd[30:0]}, 32'h8000_0000);
   endtask
   task automatic t_start();
      i_plc.select(8'hae);
      i_plc.pulse(B_START);
      exp_req(task_io_pkg::REQ_START, 1'b0);
      chk(last_num, 8'hae);
      @(posedge clock);
      base_in.task_sel <= 8'h35;
      bpulse(3);
      exp_req(task_io_pkg::REQ_START, 1'b1);
      chk(last_num, 8'h35);
   endtask
   task automatic t_next();
      drv_stat(32'h0);
      i_plc.pulse(B_NEXT);
      chk(motion_req.valid, 1'b0);
      drv_stat(32'h1);
      exp_req(task_io_pkg::REQ_NEXT, 1'b0);
      apb(1'b1, task_io_pkg::CTRL_OFS, 32'h6);
      bpulse(2);
      exp_req(task_io_pkg::REQ_NEXT, 1'b0);
   endtask
   task automatic t_resume_jog();
      i_plc.pulse(B_RES);
      exp_req(task_io_pkg::REQ_RESUME, 1'b0);
      bpulse(1);
      exp_req(task_io_pkg::REQ_RESUME, 1'b0);
      i_plc.level(B_JOG, 1'b1);
      exp_req(task_io_pkg::REQ_JOG_ON, 1'b0);
      i_plc.level(B_JOG, 1'b0);
      exp_req(task_io_pkg::REQ_JOG_OFF, 1'b0);
   endtask
   task automatic t_clear();
      logic [7:0] cnt = '0;
      fork
         i_plc.pulse(B_CLR);
         repeat (20) begin
            @(negedge clock);
            cnt = cnt + warn_clear;
         end
      join
      chk(cnt, 8'h1);
   endtask
   task automatic t_ref();
      apb(1'b1, task_io_pkg::CTRL_OFS, 32'h0);
      i_plc.level(B_REF, 1'b1);
      chk(ref_switch, 1'b1);
      apb(1'b1, task_io_pkg::CTRL_OFS, 32'h1);
      drv_stat(32'h1);
      chk(ref_switch, 1'b0);
      @(posedge clock);
      base_in.ref_sw <= 1'b1;
      i_plc.level(B_REF, 1'b0);
      chk(ref_switch, 1'b1);
   endtask
   task automatic t_outs();
      drv_stat(32'h0);
      chk(in_position_out, 1'b0);
      @(posedge clock);
      preset_active <= 6'h2a;
      drv_stat(32'h1);
      chk(in_position_out, 1'b1);
      chk(pos_flag_out, 6'h2a);
      apb(1'b1, task_io_pkg::CTRL_OFS, 32'h40);
      drv_stat(32'h9);
      chk(pos_flag_out[0], 1'b0);
      drv_stat(32'h1);
      chk(pos_flag_out[0], 1'b1);
   endtask
   task automatic t_prog();
      apb(1'b1, task_io_pkg::CTRL_OFS, 32'h0);
      seq(32'h7);
      chk(sequence_progress_out, 1'b0);
      seq(32'h3);
      chk(sequence_progress_out, 1'b1);
      seq(32'h3);
      chk(sequence_progress_out, 1'b0);
      apb(1'b1, task_io_pkg::CTRL_OFS, 32'h10);
      @(posedge clock);
      motion_stat <= 32'h3;
      @(posedge clock);
      motion_stat <= 32'h1;
      @(negedge clock);
      chk(sequence_progress_out, 1'b1);
      drv_stat(32'h1);
      chk(sequence_progress_out, 1'b0);
      apb(1'b1, task_io_pkg::CTRL_OFS, 32'h20);
      drv_stat(32'h1);
      chk(sequence_progress_out, 1'b1);
      drv_stat(32'h0);
      chk(sequence_progress_out, 1'b0);
      drv_stat(32'h1);
   endtask
   task automatic t_irq();
      apb(1'b1, task_io_pkg::IRQ_STAT_OFS, 32'hff);
      apb(1'b1, task_io_pkg::IRQ_MASK_OFS, 32'h1);
      i_plc.pulse(B_START);
      exp_req(task_io_pkg::REQ_START, 1'b0);
      chk(irq, 1'b1);
      apb(1'b1, task_io_pkg::IRQ_MASK_OFS, 32'h0);
      drv_stat(32'h1);
      chk(irq, 1'b0);
      apb(1'b1, task_io_pkg::IRQ_MASK_OFS, 32'h1);
      apb(1'b1, task_io_pkg::IRQ_STAT_OFS, 32'h1);
      drv_stat(32'h1);
      chk(irq, 1'b0);
   endtask
   task automatic print_verdict();
      if (failures == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge clock);
      rst_n <= 1'b1;
      repeat (3) @(posedge clock);
      t_regs();
      t_start();
      t_next();
      t_resume_jog();
      t_clear();
      t_ref();
      t_outs();
      t_prog();
      t_irq();
      print_verdict();
   end
   // Whole run needs well under this many cycles
   initial begin
      repeat (20000) @(posedge clock);
      failures++;
      print_verdict();
   end
endmodule
`default_nettype wire
